//--- asd_map.vh
// constants for the 8-bit alu/status datapath
// included by asd_datapath.v; definitions only
`ifndef ASD_MAP_VH
`define ASD_MAP_VH

// operation codes on op_sel
`define ASD_OP_ADD   4'h0
`define ASD_OP_ADDC  4'h1
`define ASD_OP_SUB   4'h2
`define ASD_OP_SUBB  4'h3
`define ASD_OP_AND   4'h4
`define ASD_OP_IOR   4'h5
`define ASD_OP_XOR   4'h6
`define ASD_OP_RLC   4'h7
`define ASD_OP_RRC   4'h8
`define ASD_OP_MOVF  4'h9
`define ASD_OP_MOVWF 4'hA
`define ASD_OP_MOVFF 4'hB
`define ASD_OP_MUL   4'hC
`define ASD_OP_NOP   4'hF

// destination select on dest_sel
`define ASD_DST_ACC  1'b0
`define ASD_DST_FILE 1'b1

// status byte field positions
`define ASD_ST_C     0
`define ASD_ST_DC    1
`define ASD_ST_Z     2
`define ASD_ST_OV    3

// reset values
`define ASD_ACC_RST  8'h00
`define ASD_ST_RST   4'h0
`define ASD_PRD_RST  16'h0000
`define ASD_EXW_RST  16'h0000

// data-space address of the accumulator
`define ASD_ACC_ADDR 8'h0A

`endif

//--- asd_datapath.v
// 8-bit alu, working accumulator, status flags and 8x8 multiplier
// assumes an instruction decoder drives op/dest/file operands each
// execute cycle, and writes results back to data memory from file_wr_*
// logic ops and moves touch only zero; shifts move carry as well
//
// Contract
// [RULE_01] 8-bit add, subtract, shift, logic operations
// [RULE_02] arithmetic is two's complement
// [RULE_03] accumulator combined with any file register
// [RULE_04] accumulator is 8-bit operand/result register
// [RULE_05] carry, nibble and zero flags per instruction
// [RULE_06] subtraction carries act as borrows
// [RULE_07] overflow from result bits 6 and 7
// [RULE_08] 8x8 multiply gives 16-bit product, one cycle
// [RULE_09] file-to-file move bypasses the accumulator
// [RULE_10] instruction words are 16 bits, one fetch
// [RULE_11] fetch overlaps execute; one-cycle ALU ops
// [RULE_12] accumulator visible in data address space
// [RULE_13] zero flag set on zero result, else cleared
`timescale 1ns/1ps
`default_nettype none
`include "asd_map.vh"

module asd_datapath #(
    parameter DW = 8
) (
    // clock and reset
    input  wire            mclk,
    input  wire            rst,
    // instruction fetch
    input  wire [15:0]     instr_word,
    input  wire            instr_valid,
    // decoded execute controls
    input  wire [3:0]      op_sel,
    input  wire            dest_sel,
    input  wire            flag_update,
    input  wire            mul_present,
    // file register operands from data memory
    input  wire [DW-1:0]   file_rd_data,
    input  wire [DW-1:0]   file_src_data,
    // accumulator access as a data-space location
    input  wire            acc_wr_en,
    input  wire [DW-1:0]   acc_wr_data,
    // results
    output reg  [15:0]     exec_word_q,
    output reg             exec_valid_q,
    output reg  [DW-1:0]   working_accumulator_q,
    output reg             file_wr_en_q,
    output reg  [DW-1:0]   file_wr_data_q,
    output reg  [2*DW-1:0] product_q,
    // status flags
    output reg             carry_flag_q,
    output reg             nibble_borrow_flag_q,
    output reg             zero_flag_q,
    output reg             sign_flip_flag_q
);

    reg  [DW:0]     sum_d;
    reg  [4:0]      nib_d;
    reg  [DW-1:0]   res_d;
    reg             wr_file_d;
    reg             wr_acc_d;
    reg             c_d;
    reg             dc_d;
    reg             ov_d;
    reg             arith_d;
    reg  [DW-1:0]   b_inv;
    reg             flag_op_d;
    wire [2*DW-1:0] mul_w;

    // status reset image as a named value, since a literal cannot be indexed
    localparam [3:0] ST_RST_V = `ASD_ST_RST;
    localparam       ST_C_RST  = ST_RST_V[`ASD_ST_C];
    localparam       ST_DC_RST = ST_RST_V[`ASD_ST_DC];
    localparam       ST_Z_RST  = ST_RST_V[`ASD_ST_Z];
    localparam       ST_OV_RST = ST_RST_V[`ASD_ST_OV];

    // full-width product; the upper byte lands in product_q[15:8]
    assign mul_w = working_accumulator_q * file_rd_data; // RULE_08

    always @*
    begin
        b_inv     = ~working_accumulator_q;
        sum_d     = {1'b0, working_accumulator_q};
        nib_d     = 5'h00;
        res_d     = working_accumulator_q;
        wr_file_d = 1'b0;
        wr_acc_d  = 1'b0;
        c_d       = carry_flag_q;
        dc_d      = nibble_borrow_flag_q;
        ov_d      = sign_flip_flag_q;
        arith_d   = 1'b0;
        flag_op_d = 1'b1;
        // arithmetic first: the result case below reads sum_d
        case (op_sel)
            `ASD_OP_ADD, `ASD_OP_ADDC:
            begin
                // two's complement add of acc and file operand
                sum_d = {1'b0, working_accumulator_q} + {1'b0, file_rd_data}
                      + {{DW{1'b0}}, (op_sel == `ASD_OP_ADDC) & carry_flag_q}; // RULE_02
                nib_d = {1'b0, working_accumulator_q[3:0]}
                      + {1'b0, file_rd_data[3:0]}
                      + {4'h0, (op_sel == `ASD_OP_ADDC) & carry_flag_q};
                arith_d = 1'b1;
            end
            `ASD_OP_SUB, `ASD_OP_SUBB:
            begin
                // file minus acc as file + ~acc + 1, or + carry for SUBB; carry high means no borrow
                sum_d = {1'b0, file_rd_data} + {1'b0, b_inv}
                      + {{DW{1'b0}}, (op_sel == `ASD_OP_SUB) | carry_flag_q}; // RULE_06
                nib_d = {1'b0, file_rd_data[3:0]}
                      + {1'b0, b_inv[3:0]}
                      + {4'h0, (op_sel == `ASD_OP_SUB) | carry_flag_q}; // RULE_06
                arith_d = 1'b1;
            end
            default:
            begin
                sum_d = {1'b0, working_accumulator_q};
            end
        endcase
        case (op_sel)
            `ASD_OP_ADD, `ASD_OP_ADDC, `ASD_OP_SUB, `ASD_OP_SUBB:
                res_d = sum_d[DW-1:0]; // RULE_01
            `ASD_OP_AND:   res_d = working_accumulator_q & file_rd_data; // RULE_03
            `ASD_OP_IOR:   res_d = working_accumulator_q | file_rd_data;
            `ASD_OP_XOR:   res_d = working_accumulator_q ^ file_rd_data;
            `ASD_OP_RLC:   res_d = {file_rd_data[DW-2:0], carry_flag_q};
            `ASD_OP_RRC:   res_d = {carry_flag_q, file_rd_data[DW-1:1]};
            `ASD_OP_MOVF:  res_d = file_rd_data;
            `ASD_OP_MOVWF: res_d = working_accumulator_q;
            `ASD_OP_MOVFF: res_d = file_src_data; // RULE_09
            default:       res_d = working_accumulator_q;
        endcase
        if (arith_d)
        begin
            c_d  = sum_d[DW]; // RULE_05
            dc_d = nib_d[4];
            // sign flip: carry into bit 7 differs from carry out of it
            ov_d = sum_d[DW] ^ (res_d[DW-1] ^ sum_d[DW-1] ^ res_d[DW-1]
                 ^ working_accumulator_q[DW-1] ^ file_rd_data[DW-1]
                 ^ ((op_sel == `ASD_OP_SUB) | (op_sel == `ASD_OP_SUBB)
                    ? 1'b1 : 1'b0)); // RULE_07
        end
        else if (op_sel == `ASD_OP_RLC)
            c_d = file_rd_data[DW-1];
        else if (op_sel == `ASD_OP_RRC)
            c_d = file_rd_data[0];
        // write-back routing: MOVWF and MOVFF always land in the file register; MOVF follows dest_sel
        case (op_sel)
            `ASD_OP_MOVWF, `ASD_OP_MOVFF:
                wr_file_d = 1'b1; // RULE_09
            `ASD_OP_MUL, `ASD_OP_NOP:
            begin
                // no alu result here, so the zero test would be stale
                wr_file_d = 1'b0;
                flag_op_d = 1'b0;
            end
            default:
            begin
                wr_file_d = (dest_sel == `ASD_DST_FILE);
                wr_acc_d  = (dest_sel == `ASD_DST_ACC);
            end
        endcase
    end

    // two-stage pipe: a fetched word is executed on the following cycle
    always @(posedge mclk)
    begin
        if (rst)
        begin
            exec_word_q  <= `ASD_EXW_RST;
            exec_valid_q <= 1'b0;
        end
        else
        begin
            exec_word_q  <= instr_word; // RULE_10
            exec_valid_q <= instr_valid; // RULE_11
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            working_accumulator_q <= `ASD_ACC_RST;
            file_wr_en_q          <= 1'b0;
            file_wr_data_q        <= `ASD_ACC_RST;
            product_q             <= `ASD_PRD_RST;
            carry_flag_q          <= ST_C_RST;
            nibble_borrow_flag_q  <= ST_DC_RST;
            zero_flag_q           <= ST_Z_RST;
            sign_flip_flag_q      <= ST_OV_RST;
        end
        else
        begin
            file_wr_en_q   <= exec_valid_q & wr_file_d;
            // data follows the result every cycle; only the enable qualifies
            file_wr_data_q <= res_d;
            // an alu write wins over a data-space write in the same cycle;
            // the decoder is expected never to issue both at once
            if (exec_valid_q & wr_acc_d)
                working_accumulator_q <= res_d; // RULE_04
            else if (acc_wr_en)
                // data-space write of the accumulator location
                working_accumulator_q <= acc_wr_data; // RULE_12
            // with no multiplier the old product simply stands
            if (exec_valid_q & mul_present & (op_sel == `ASD_OP_MUL))
                product_q <= mul_w; // RULE_08
            // flags move only for ops that produce an alu result
            if (exec_valid_q & flag_update & flag_op_d)
            begin
                carry_flag_q         <= c_d; // RULE_05
                nibble_borrow_flag_q <= dc_d;
                sign_flip_flag_q     <= ov_d;
                zero_flag_q          <= (res_d == {DW{1'b0}}); // RULE_13
            end
        end
    end

endmodule

`default_nettype wire

//--- asd_chk_checker.sv
// assertion checker for asd_datapath, bound to every instance
// assumes results land one edge after the op is seen in exec
`timescale 1ns/1ps
`default_nettype none
`include "asd_map.vh"
module asd_chk #(parameter DW = 8) (
    // clock, reset and controls
    input wire logic mclk, rst, instr_valid, flag_update, dest_sel,
    input wire logic mul_present, acc_wr_en, exec_valid_q, file_wr_en_q,
    input wire logic [3:0] op_sel,
    input wire logic [15:0] instr_word, exec_word_q, product_q,
    // operands and results
    input wire logic [DW-1:0] file_rd_data, file_src_data, file_wr_data_q,
    input wire logic [DW-1:0] working_accumulator_q,
    // flags
    input wire logic carry_flag_q, nibble_borrow_flag_q,
    input wire logic zero_flag_q, sign_flip_flag_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [7:0]  a = working_accumulator_q;
    wire logic [7:0]  f = file_rd_data;
    wire logic [8:0]  sum = a + f;
    wire logic [7:0]  s7 = a[6:0] + f[6:0];
    wire logic [4:0]  s4 = a[3:0] + f[3:0];
    wire logic [15:0] prd = a * f;
    wire logic        ovf = s7[7] ^ sum[8];
    wire logic        nb = f >= a;
    wire logic        nbn = f[3:0] >= a[3:0];
    sequence s_go(logic [3:0] o); exec_valid_q && op_sel == o; endsequence
    sequence s_upd(logic [3:0] o); s_go(o) ##0 flag_update; endsequence
    property p_exec; !$past(rst) |-> exec_valid_q == $past(instr_valid)
        && exec_word_q == $past(instr_word); endproperty
    a_exec: assert property (p_exec) else $error("exec stage");
    property p_add; s_upd(`ASD_OP_ADD) ##0 !dest_sel |=> a == $past(sum[7:0])
        && carry_flag_q == $past(sum[8]); endproperty
    a_add: assert property (p_add) else $error("add");
    property p_dc; s_upd(`ASD_OP_ADD) |=>
        nibble_borrow_flag_q == $past(s4[4]); endproperty
    a_dc: assert property (p_dc) else $error("nibble carry");
    property p_ov; s_upd(`ASD_OP_ADD) |=>
        sign_flip_flag_q == $past(ovf); endproperty
    a_ov: assert property (p_ov) else $error("overflow");
    property p_z; s_upd(`ASD_OP_ADD) |=>
        zero_flag_q == ($past(sum[7:0]) == 8'h00); endproperty
    a_z: assert property (p_z) else $error("zero flag");
    property p_sub; s_upd(`ASD_OP_SUB) |=> carry_flag_q == $past(nb)
        && nibble_borrow_flag_q == $past(nbn); endproperty
    a_sub: assert property (p_sub) else $error("borrow");
    property p_mul; s_go(`ASD_OP_MUL) ##0 mul_present |=>
        product_q == $past(prd); endproperty
    a_mul: assert property (p_mul) else $error("product");
    property p_mov; s_go(`ASD_OP_MOVFF) ##0 !acc_wr_en |=> file_wr_en_q &&
        file_wr_data_q == $past(file_src_data) && $stable(a); endproperty
    a_mov: assert property (p_mov) else $error("file move");
endmodule
bind asd_datapath asd_chk #(.DW(DW)) asd_chk_inst (.mclk, .rst, .instr_valid,
    .flag_update, .dest_sel, .mul_present, .acc_wr_en, .exec_valid_q,
    .file_wr_en_q, .op_sel, .instr_word, .exec_word_q, .product_q,
    .file_rd_data, .file_src_data, .file_wr_data_q, .working_accumulator_q,
    .carry_flag_q, .nibble_borrow_flag_q, .zero_flag_q, .sign_flip_flag_q);
`default_nettype wire

//--- asd_fmem.sv
// one-location file register model feeding file-to-file moves
// unknown until first written, as real memory would be
`timescale 1ns/1ps
`default_nettype none
module asd_fmem (
    // write side from the datapath
    input wire logic mclk, file_wr_en_q,
    input wire logic [7:0] file_wr_data_q,
    // source operand for moves
    output logic [7:0] file_src_data
);
    always @(posedge mclk)
        if (file_wr_en_q)
            file_src_data <= file_wr_data_q;
endmodule
`default_nettype wire

//--- test_asd_datapath.sv
// self-checking bench for asd_datapath with a file register model
// assumes asd_map.vh op codes; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
`include "asd_map.vh"
module test_asd_datapath;
    logic mclk = 0, rst = 1, instr_valid = 0, dest_sel = 0, flag_update = 1;
    logic mul_present = 1, acc_wr_en = 0, exec_valid_q, file_wr_en_q;
    logic carry_flag_q, nibble_borrow_flag_q, zero_flag_q, sign_flip_flag_q;
    logic [3:0] op_sel = `ASD_OP_NOP;
    logic [7:0] file_rd_data = 8'h00, acc_wr_data = 8'h00, file_src_data;
    logic [7:0] working_accumulator_q, file_wr_data_q;
    logic [15:0] instr_word = 16'h0000, exec_word_q, product_q;
    wire logic [3:0] flg = {sign_flip_flag_q, zero_flag_q,
        nibble_borrow_flag_q, carry_flag_q};
    int error_cnt = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    asd_datapath asd_datapath_inst (
        .mclk                  (mclk),
        .rst                   (rst),
        .instr_word            (instr_word),
        .instr_valid           (instr_valid),
        .op_sel                (op_sel),
        .dest_sel              (dest_sel),
        .flag_update           (flag_update),
        .mul_present           (mul_present),
        .file_rd_data          (file_rd_data),
        .file_src_data         (file_src_data),
        .acc_wr_en             (acc_wr_en),
        .acc_wr_data           (acc_wr_data),
        .exec_word_q           (exec_word_q),
        .exec_valid_q          (exec_valid_q),
        .working_accumulator_q (working_accumulator_q),
        .file_wr_en_q          (file_wr_en_q),
        .file_wr_data_q        (file_wr_data_q),
        .product_q             (product_q),
        .carry_flag_q          (carry_flag_q),
        .nibble_borrow_flag_q  (nibble_borrow_flag_q),
        .zero_flag_q           (zero_flag_q),
        .sign_flip_flag_q      (sign_flip_flag_q)
    );
    asd_fmem asd_fmem_inst (
        .mclk           (mclk),
        .file_wr_en_q   (file_wr_en_q),
        .file_wr_data_q (file_wr_data_q),
        .file_src_data  (file_src_data)
    );
    task automatic cmp(input logic [15:0] g, e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic run(input logic [3:0] o, input logic [7:0] a, f);
        op_sel = `ASD_OP_NOP;
        acc_wr_en = 1;
        acc_wr_data = a;
        @(negedge mclk);
        acc_wr_en = 0;
        op_sel = o;
        file_rd_data = f;
        @(negedge mclk);
        $display("test op %h done", o);
    endtask
    // flags packed as {sign flip, zero, nibble, carry}, masked by m
    task automatic t(input logic [3:0] o, input logic [7:0] a, f, r,
                     input logic [3:0] e, m);
        run(o, a, f);
        cmp({8'h00, working_accumulator_q}, {8'h00, r});
        cmp({12'h000, flg & m}, {12'h000, e});
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        rst = 0;
        instr_valid = 1;
        instr_word = 16'hC35A;
        @(negedge mclk);
        cmp(exec_word_q, 16'hC35A);
        cmp(product_q, 16'h0000);
        t(`ASD_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h7, 4'hF);
        t(`ASD_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'hA, 4'hF);
        t(`ASD_OP_SUB, 8'h01, 8'h00, 8'hFF, 4'h0, 4'h7);
        t(`ASD_OP_SUB, 8'h10, 8'h10, 8'h00, 4'h7, 4'h7);
        t(`ASD_OP_AND, 8'hF0, 8'h3C, 8'h30, 4'h1, 4'h5);
        t(`ASD_OP_IOR, 8'hF0, 8'h3C, 8'hFC, 4'h1, 4'h5);
        t(`ASD_OP_XOR, 8'h3C, 8'h3C, 8'h00, 4'h5, 4'h5);
        t(`ASD_OP_RLC, 8'h00, 8'h81, 8'h03, 4'h1, 4'h1);
        t(`ASD_OP_ADDC, 8'h0F, 8'h00, 8'h10, 4'h2, 4'hF);
        t(`ASD_OP_SUBB, 8'h01, 8'h05, 8'h03, 4'h3, 4'hF);
        t(`ASD_OP_RRC, 8'h00, 8'h02, 8'h81, 4'h0, 4'h1);
        t(`ASD_OP_MOVF, 8'h11, 8'h00, 8'h00, 4'h4, 4'h4);
        flag_update = 0;
        t(`ASD_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'h6, 4'hF);
        flag_update = 1;
        run(`ASD_OP_MUL, 8'hFF, 8'hFF);
        cmp(product_q, 16'hFE01);
        mul_present = 0;
        run(`ASD_OP_MUL, 8'h0F, 8'h11);
        cmp(product_q, 16'hFE01);
        mul_present = 1;
        dest_sel = 1;
        run(`ASD_OP_MOVWF, 8'h5A, 8'h00);
        cmp({7'h00, file_wr_en_q, file_wr_data_q}, 16'h015A);
        run(`ASD_OP_MOVFF, 8'h33, 8'h00);
        cmp({7'h00, file_wr_en_q, file_wr_data_q}, 16'h015A);
        cmp({8'h00, working_accumulator_q}, 16'h0033);
        op_sel = `ASD_OP_NOP;
        @(negedge mclk);
        cmp({15'h0000, file_wr_en_q}, 16'h0000);
        rst = 1;
        @(negedge mclk);
        cmp({working_accumulator_q, 7'h00, exec_valid_q}, 16'h0000);
        final_report;
    end
    // whole sequence needs about 53 cycles
    initial
    begin
        #3000;
        error_cnt++;
        final_report;
    end
endmodule
`default_nettype wire
